// ---- include/lss_pkg.sv ----
// package for the load switch supervisor control block
// assumes one 200 MHz clock and a synchronous active-high reset
package lss_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_ENABLE  = 4'h0;
  localparam logic [3:0] OFS_SWCFG   = 4'h1;
  localparam logic [3:0] OFS_LIMIT   = 4'h2;
  localparam logic [3:0] OFS_CONTROL = 4'h3;
  localparam logic [3:0] OFS_LDO     = 4'h4;
  localparam logic [3:0] OFS_IRQ     = 4'h5;
  localparam logic [3:0] OFS_STATUS  = 4'h6;

  // field positions
  localparam int ENB_FIRST      = 0;
  localparam int CFG_DCHRG_LSB  = 0;
  localparam int CFG_SHED_LSB   = 3;
  localparam int LIM_SECOND_LSB = 0;
  localparam int LIM_THIRD_LSB  = 2;
  localparam int CTL_PF_SHUT    = 0;
  localparam int IRQ_ILIM_LSB   = 0;
  localparam int IRQ_FAULT_LSB  = 3;

  // reset values
  localparam logic [2:0] ENABLE_RST  = 3'h0;
  localparam logic [2:0] DCHRG_RST   = 3'h0;
  localparam logic [2:0] SHED_RST    = 3'h0;
  localparam logic [1:0] LIM_RST     = 2'h0;
  localparam logic       PF_SHUT_RST = 1'b0;
  localparam logic [5:0] LDO_RST     = 6'h1F;  // code for 1.8 V

  // brown-out ride-through time
  localparam int DIP_MS      = 5;
  localparam int CLK_MHZ     = 200;
  localparam int DIP_CYCLES  = DIP_MS * 1000 * CLK_MHZ;  // 1,000,000

  // operating states of the supervisor
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_WAIT   = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_DOWN   = 4'h8
  } lss_state_t;

  // comparator inputs grouped together
  typedef struct packed {
    logic       uvlo;      // input below undervoltage level
    logic       powerfail; // power-fail comparator tripped
    logic [2:0] overtemp;  // per-switch overtemperature
    logic [2:0] ilimit;    // per-switch current limiting
    logic       ls2_uv;    // second switch input below 2.7 V
  } lss_comp_t;

  // whole state of the controller
  typedef struct packed {
    lss_state_t  state;
    lss_comp_t   s1;
    lss_comp_t   s2;
    logic [2:0]  enable;
    logic [2:0]  dchrg;
    logic [2:0]  shed;
    logic [1:0]  lim2;
    logic [1:0]  lim3;
    logic        pf_shut;
    logic [5:0]  ldo;
    logic [2:0]  irq_ilim;
    logic [2:0]  irq_fault;
    logic        pf_prev;
    logic [31:0] dip_cnt;
    logic [7:0]  rdata;
  } lss_regs_t;

endpackage : lss_pkg

// ---- logic/lss_ctrl.sv ----
// control logic of the load switch supervisor: backup power-good,
// three load switches, brown-out handling, power-fail routing and power-path
// assumes comparator inputs synchronous to SYS_CLK after the local two-stage
// synchroniser, and RESET asserted whenever the core regulator collapses
//
// Notes on behaviour
// R01 - backup good is AND of both rails
// R02 - backup rail faults touch nothing else
// R03 - backup rails recover by themselves
// R04 - undervoltage starts power-down sequence
// R05 - below 2.5 V reset, all off, discharge
// R06 - each switch follows its enable bit
// R07 - sequencer drives first switch only
// R08 - discharge off at reset, active when disabled
// R09 - power-fail sheds flagged switches until rewritten
// R10 - current limiting raises interrupt, stays on
// R11 - overtemperature forces off, flags fault, recovers
// R12 - second switch limit from two bits
// R13 - second switch off below 2.7 V input
// R14 - third switch limit from two bits
// R15 - regulator setting resets to 1.8 V
// R16 - dip survives only if shorter than 5 ms
// R17 - power-fail shutdown only when control bit set
// R18 - no power-fail status or interrupt
// R19 - powered states pick main backup input
// R20 - regulator collapse: reset, off, main input
// R21 - comparators synchronised before use
//
// The register offsets and strobed register access were decided locally.
module lss_ctrl #(
  parameter int DIP_CYCLES = lss_pkg::DIP_CYCLES
) (
  input  wire logic       SYS_CLK,         // 200 MHz clock
  input  wire logic       RESET,           // sync reset, high when core regulator collapses
  input  wire logic [3:0] ADDR,            // register index
  input  wire logic [7:0] WDATA,           // write data
  input  wire logic       WR,              // write strobe
  input  wire logic       RD,              // read strobe
  output logic      [7:0] RDATA,           // read data, cycle after RD
  input  wire logic       RAIL_LOW_GOOD,   // low backup rail in regulation
  input  wire logic       RAIL_HIGH_GOOD,  // high backup rail in regulation
  input  wire logic       POWER_UP_EVENT,  // power-up request from pin logic
  input  wire logic       SEQ_FIRST_ON,    // sequencer request for first switch
  input  wire logic       SEQ_FIRST_WR,    // sequencer updates first switch
  input  wire logic       SEQ_DONE,        // power-down sequence finished
  input  wire logic       UVLO_CMP,        // input below undervoltage level
  input  wire logic       POWERFAIL_CMP,   // power-fail comparator tripped
  input  wire logic [2:0] OVERTEMP_CMP,    // per-switch overtemperature
  input  wire logic [2:0] ILIMIT_CMP,      // per-switch current limiting
  input  wire logic       LS2_UV_CMP,      // second switch input below 2.7 V
  input  wire logic       CC_HIGHER,       // coin cell 150 mV above main (analog hysteresis)
  output logic            BACKUP_POWER_GOOD, // both backup rails good
  output logic            POWER_DOWN_START,  // pulse to power-down sequencer
  output logic      [2:0] SWITCH_ON,       // load switch gate enables
  output logic      [2:0] SWITCH_DCHRG,    // load switch discharge paths
  output logic      [1:0] SECOND_LIMIT,    // second switch current limit select
  output logic      [1:0] THIRD_LIMIT,     // third switch current limit select
  output logic      [5:0] REGULATOR_CODE,  // general regulator voltage code
  output logic            SELECT_COIN_CELL // power-path on coin cell input
);

  lss_pkg::lss_regs_t r, nxt;
  logic [2:0] blocked;
  logic       pf_edge;
  logic       dip_expired;

  // switch held off by local protection, overrides the enable bit
  always_comb begin
    blocked = r.s2.overtemp; // R11
    blocked[1] = r.s2.overtemp[1] | r.s2.ls2_uv; // R13
  end

  assign pf_edge     = r.s2.powerfail & ~r.pf_prev;
  assign dip_expired = (r.dip_cnt >= 32'(DIP_CYCLES - 1));

  // next-state logic
  always_comb begin
    nxt = r;
    // two-stage synchroniser; only s2 is looked at
    nxt.s1 = '{UVLO_CMP, POWERFAIL_CMP, OVERTEMP_CMP, ILIMIT_CMP, LS2_UV_CMP}; // R21
    nxt.s2 = r.s1; // R21
    nxt.pf_prev = r.s2.powerfail;
    nxt.rdata = 8'h00;

    // register writes
    if (WR) begin
      unique case (ADDR)
        lss_pkg::OFS_ENABLE:  nxt.enable = WDATA[2:0]; // R06
        lss_pkg::OFS_SWCFG: begin
          nxt.dchrg = WDATA[lss_pkg::CFG_DCHRG_LSB +: 3]; // R08
          nxt.shed  = WDATA[lss_pkg::CFG_SHED_LSB +: 3];
        end
        lss_pkg::OFS_LIMIT: begin
          nxt.lim2 = WDATA[lss_pkg::LIM_SECOND_LSB +: 2]; // R12
          nxt.lim3 = WDATA[lss_pkg::LIM_THIRD_LSB +: 2]; // R14
        end
        lss_pkg::OFS_CONTROL: nxt.pf_shut = WDATA[lss_pkg::CTL_PF_SHUT]; // R17
        lss_pkg::OFS_LDO:     nxt.ldo = WDATA[5:0];
        // write one to clear; a pending event still wins below
        lss_pkg::OFS_IRQ: begin
          nxt.irq_ilim  = r.irq_ilim & ~WDATA[lss_pkg::IRQ_ILIM_LSB +: 3];
          nxt.irq_fault = r.irq_fault & ~WDATA[lss_pkg::IRQ_FAULT_LSB +: 3];
        end
        default: ;
      endcase
    end

    // sequencer owns only the first switch
    if (SEQ_FIRST_WR) nxt.enable[lss_pkg::ENB_FIRST] = SEQ_FIRST_ON; // R07

    // shedding clears enable bits, so recovery needs a fresh write
    if (pf_edge) nxt.enable = nxt.enable & ~r.shed; // R09

    // sticky events, set beats clear
    nxt.irq_ilim  = nxt.irq_ilim | (r.s2.ilimit & r.enable); // R10
    nxt.irq_fault = nxt.irq_fault | (blocked & r.enable); // R11 R13

    // state machine; backup rail status never enters here
    unique case (r.state)
      lss_pkg::ST_OFF: begin
        if (POWER_UP_EVENT && !r.s2.uvlo) nxt.state = lss_pkg::ST_WAIT;
      end
      lss_pkg::ST_WAIT, lss_pkg::ST_ACTIVE: begin
        if (r.state == lss_pkg::ST_WAIT) nxt.state = lss_pkg::ST_ACTIVE;
        // ride through a short dip, shut down after 5 ms
        if (r.s2.uvlo) begin
          nxt.dip_cnt = r.dip_cnt + 32'h1; // R16
          if (dip_expired) nxt.state = lss_pkg::ST_DOWN; // R04 R16
        end else begin
          nxt.dip_cnt = 32'h0;
        end
        if (r.s2.powerfail && r.pf_shut) nxt.state = lss_pkg::ST_DOWN; // R17
      end
      lss_pkg::ST_DOWN: begin
        nxt.dip_cnt = 32'h0;
        if (SEQ_DONE) begin
          nxt.state = lss_pkg::ST_OFF;
          // all three switches drop as the off state is entered
          nxt.enable = 3'h0;
        end
      end
      default: nxt.state = lss_pkg::ST_OFF;
    endcase

    // register reads, data valid the next cycle; no power-fail bit exists
    if (RD) begin // R18
      unique case (ADDR)
        lss_pkg::OFS_ENABLE:  nxt.rdata = {5'h00, r.enable};
        lss_pkg::OFS_SWCFG:   nxt.rdata = {2'h0, r.shed, r.dchrg};
        lss_pkg::OFS_LIMIT:   nxt.rdata = {4'h0, r.lim3, r.lim2};
        lss_pkg::OFS_CONTROL: nxt.rdata = {7'h00, r.pf_shut};
        lss_pkg::OFS_LDO:     nxt.rdata = {2'h0, r.ldo};
        lss_pkg::OFS_IRQ:     nxt.rdata = {2'h0, r.irq_fault, r.irq_ilim};
        lss_pkg::OFS_STATUS:  nxt.rdata = {4'h0, r.state};
        default:              nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register; reset models the core regulator collapse
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin // R05 R20
      r         <= '0;
      r.state   <= lss_pkg::ST_OFF;
      r.enable  <= lss_pkg::ENABLE_RST;
      r.dchrg   <= lss_pkg::DCHRG_RST; // R08
      r.shed    <= lss_pkg::SHED_RST;
      r.lim2    <= lss_pkg::LIM_RST;
      r.lim3    <= lss_pkg::LIM_RST;
      r.pf_shut <= lss_pkg::PF_SHUT_RST; // R17
      r.ldo     <= lss_pkg::LDO_RST; // R15
    end else begin
      r <= nxt;
    end
  end

  // outputs; during reset all three switches are off and discharging
  assign BACKUP_POWER_GOOD = RAIL_LOW_GOOD & RAIL_HIGH_GOOD; // R01 R02 R03
  assign POWER_DOWN_START  = (r.state != lss_pkg::ST_DOWN) && (nxt.state == lss_pkg::ST_DOWN); // R04
  assign SWITCH_ON    = RESET ? 3'h0 : (r.enable & ~blocked); // R06 R10 R11 R05
  assign SWITCH_DCHRG = RESET ? 3'h7 : (r.dchrg & ~SWITCH_ON); // R08 R05
  assign SECOND_LIMIT   = r.lim2; // R12
  assign THIRD_LIMIT    = r.lim3; // R14
  assign REGULATOR_CODE = r.ldo;
  assign RDATA          = r.rdata;
  // powered states force main input; off picks the higher
  assign SELECT_COIN_CELL = (r.state == lss_pkg::ST_OFF) & ~RESET & CC_HIGHER; // R19 R20

endmodule : lss_ctrl

// ---- testbench/lss_host.sv ----
// host model: the processor side of the plain register port
// assumes strobes launched just after a rising SYS_CLK edge
module lss_host (
  input  wire logic       SYS_CLK, // clock
  output logic      [3:0] ADDR,    // index
  output logic      [7:0] WDATA,   // write data
  output logic            WR,      // write strobe
  output logic            RD,      // read strobe
  input  wire logic [7:0] RDATA    // read data
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle from time zero so no strobe is seen as unknown
  initial begin
    {ADDR, WDATA, WR, RD} = 14'h0000;
  end

  // one-cycle write, dropped on the edge that takes it
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    @(posedge SYS_CLK);
    d = RDATA;
  endtask : rd
endmodule : lss_host

// ---- testbench/lss_ctrl_checker.sv ----
// assertions on the ports of the load switch supervisor control
// assumes sync active-high RESET and two-flop comparator synchronisers
module lss_ctrl_checker #(
  parameter int DIP_CYCLES = lss_pkg::DIP_CYCLES // ride-through count
) (
  input wire logic       SYS_CLK,           // clock
  input wire logic       RESET,             // reset
  input wire logic       RAIL_LOW_GOOD,     // rail ok
  input wire logic       RAIL_HIGH_GOOD,    // rail ok
  input wire logic       POWER_UP_EVENT,    // power-up
  input wire logic       UVLO_CMP,          // undervoltage
  input wire logic       POWERFAIL_CMP,     // power-fail
  input wire logic [2:0] OVERTEMP_CMP,      // overtemp
  input wire logic       LS2_UV_CMP,        // input low
  input wire logic       CC_HIGHER,         // coin cell higher
  input wire logic       BACKUP_POWER_GOOD, // backup good
  input wire logic       POWER_DOWN_START,  // sequencer kick
  input wire logic [2:0] SWITCH_ON,         // gates
  input wire logic [2:0] SWITCH_DCHRG,      // discharges
  input wire logic [5:0] REGULATOR_CODE,    // regulator
  input wire logic       SELECT_COIN_CELL   // power-path
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] uv_cnt;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // run length of raw undervoltage; bounds the synced one while raw stays high, but clears two cycles before it
  always_ff @(posedge SYS_CLK) uv_cnt <= (RESET || !UVLO_CMP) ? 32'h0 : uv_cnt + 32'h1;

  property p_bu_good; BACKUP_POWER_GOOD == (RAIL_LOW_GOOD && RAIL_HIGH_GOOD); endproperty
  a_bu_good: assert property (p_bu_good) else $error("backup good is not the AND of rails");
  property p_dchrg; (SWITCH_DCHRG & SWITCH_ON) == 3'h0; endproperty
  a_dchrg: assert property (p_dchrg) else $error("discharge on an enabled switch");
  property p_hot; OVERTEMP_CMP[2] [*3] |-> !SWITCH_ON[2]; endproperty
  a_hot: assert property (p_hot) else $error("hot switch still on");
  property p_ls2_low; LS2_UV_CMP [*3] |-> !SWITCH_ON[1]; endproperty
  a_ls2_low: assert property (p_ls2_low) else $error("second switch on with low input");
  property p_kick; POWER_DOWN_START |=> !POWER_DOWN_START; endproperty
  a_kick: assert property (p_kick) else $error("power-down kick longer than a cycle");
  property p_cause; POWER_DOWN_START |-> uv_cnt >= DIP_CYCLES || $past(POWERFAIL_CMP, 2); endproperty
  a_cause: assert property (p_cause) else $error("power-down without a lasting cause");
  property p_path; SELECT_COIN_CELL |-> CC_HIGHER; endproperty
  a_path: assert property (p_path) else $error("coin cell picked while lower");
  // a power-up request with no synced undervoltage is taken, so the off state is left and the coin cell dropped
  property p_up; POWER_UP_EVENT && !$past(UVLO_CMP, 2) |=> !SELECT_COIN_CELL; endproperty
  a_up: assert property (p_up) else $error("coin cell picked while powered");
  property p_rst; disable iff (1'b0) RESET && $past(RESET) |->
    SWITCH_ON == 3'h0 && SWITCH_DCHRG == 3'h7 && REGULATOR_CODE == lss_pkg::LDO_RST; endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong during reset");
endmodule : lss_ctrl_checker

bind lss_ctrl lss_ctrl_checker #(.DIP_CYCLES(DIP_CYCLES)) i_lss_ctrl_checker (.*);

// ---- testbench/lss_ctrl_tb_top.sv ----
// self-checking bench for the load switch supervisor control
// assumes lss_host for register access and the bound port checker
module lss_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       SYS_CLK, RESET, RAIL_LOW_GOOD, RAIL_HIGH_GOOD, POWER_UP_EVENT, SEQ_FIRST_ON, SEQ_FIRST_WR;
  logic       SEQ_DONE, UVLO_CMP, POWERFAIL_CMP, LS2_UV_CMP, CC_HIGHER, WR, RD;
  logic       BACKUP_POWER_GOOD, POWER_DOWN_START, SELECT_COIN_CELL;
  logic [2:0] OVERTEMP_CMP, ILIMIT_CMP, SWITCH_ON, SWITCH_DCHRG;
  logic [1:0] SECOND_LIMIT, THIRD_LIMIT;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [5:0] REGULATOR_CODE;
  int         checks, fail_count;

  lss_ctrl #(.DIP_CYCLES(20)) i_lss_ctrl (.*);
  lss_host i_lss_host (.*);

  // 200 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  task cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : cyc

  task chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_lss_host.rd(a, d);
    chk(d, e);
  endtask : rdc

  // the kick is a single cycle, so every edge of the window is looked at
  task pd(input int n, input logic e);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge SYS_CLK);
      s = s | POWER_DOWN_START;
    end
    chk(s, e);
  endtask : pd

  // pulses start on a rising edge, so two calls never touch one signal in one step
  task pul(input int w);
    @(posedge SYS_CLK);
    if (w) SEQ_DONE <= 1'b1;
    else POWER_UP_EVENT <= 1'b1;
    cyc(1);
    {SEQ_DONE, POWER_UP_EVENT} <= 2'h0;
  endtask : pul

  task tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // a hang counts as a mismatch
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    {RAIL_LOW_GOOD, RAIL_HIGH_GOOD, POWER_UP_EVENT, SEQ_FIRST_ON, SEQ_FIRST_WR, SEQ_DONE, UVLO_CMP,
     POWERFAIL_CMP, LS2_UV_CMP, OVERTEMP_CMP, ILIMIT_CMP} = '0;
    RESET = 1'b1;
    CC_HIGHER = 1'b1;
    cyc(4);
    RESET <= 1'b0;
    for (int i = 0; i < 5; i++) rdc(4'(i), i == 4 ? 8'h1F : 8'h00);
    rdc(4'hF, 8'h00);
    rdc(4'h6, 8'h01);
    #1 chk(SELECT_COIN_CELL, 8'h01);
    chk(SWITCH_DCHRG, 3'h0);
    pul(0);
    rdc(4'h6, 8'h04);
    #1 chk(SELECT_COIN_CELL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      i_lss_host.wr(4'h2, 8'(k * 5));
      #1 chk(SECOND_LIMIT, 8'(k));
      chk(THIRD_LIMIT, 8'(k));
    end
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      {RAIL_LOW_GOOD, RAIL_HIGH_GOOD} <= 2'(k);
      #1 chk(BACKUP_POWER_GOOD, k == 3);
    end
    pd(4, 0);
    rdc(4'h6, 8'h04);
    i_lss_host.wr(4'h1, 8'h2F);
    #1 chk(SWITCH_DCHRG, 3'h7);
    i_lss_host.wr(4'h0, 8'h07);
    #1 chk(SWITCH_ON, 3'h7);
    cyc(1);
    POWERFAIL_CMP <= 1'b1;
    pd(6, 0);
    POWERFAIL_CMP <= 1'b0;
    rdc(4'h0, 8'h02);
    #1 chk(SWITCH_ON, 3'h2);
    rdc(4'h5, 8'h00);
    ILIMIT_CMP <= 3'h2;
    cyc(4);
    #1 chk(SWITCH_ON, 3'h2);
    rdc(4'h5, 8'h02);
    ILIMIT_CMP <= 3'h0;
    cyc(3);
    i_lss_host.wr(4'h5, 8'h02);
    rdc(4'h5, 8'h00);
    i_lss_host.wr(4'h0, 8'h07);
    OVERTEMP_CMP <= 3'h4;
    cyc(4);
    #1 chk(SWITCH_ON, 3'h3);
    chk(SWITCH_DCHRG, 3'h4);
    rdc(4'h5, 8'h20);
    OVERTEMP_CMP <= 3'h0;
    LS2_UV_CMP <= 1'b1;
    cyc(4);
    #1 chk(SWITCH_ON, 3'h5);
    rdc(4'h5, 8'h30);
    LS2_UV_CMP <= 1'b0;
    cyc(4);
    #1 chk(SWITCH_ON, 3'h7);
    i_lss_host.wr(4'h0, 8'h00);
    {SEQ_FIRST_ON, SEQ_FIRST_WR} <= 2'h3;
    cyc(1);
    SEQ_FIRST_WR <= 1'b0;
    #1 chk(SWITCH_ON, 3'h1);
    cyc(1);
    UVLO_CMP <= 1'b1;
    pd(10, 0);
    UVLO_CMP <= 1'b0;
    pd(30, 0);
    UVLO_CMP <= 1'b1;
    pd(40, 1);
    UVLO_CMP <= 1'b0;
    rdc(4'h6, 8'h08);
    pul(1);
    pul(0);
    i_lss_host.wr(4'h3, 8'h01);
    POWERFAIL_CMP <= 1'b1;
    pd(6, 1);
    POWERFAIL_CMP <= 1'b0;
    pul(1);
    rdc(4'h6, 8'h01);
    CC_HIGHER <= 1'b0;
    cyc(1);
    #1 chk(SELECT_COIN_CELL, 8'h00);
    pul(0);
    i_lss_host.wr(4'h0, 8'h07);
    CC_HIGHER <= 1'b1;
    RESET <= 1'b1;
    cyc(2);
    #1 chk(SWITCH_ON, 3'h0);
    chk(SWITCH_DCHRG, 3'h7);
    cyc(1);
    RESET <= 1'b0;
    rdc(4'h6, 8'h01);
    rdc(4'h1, 8'h00);
    tally_and_finish();
  end
endmodule : lss_ctrl_tb_top
